//--- src/rtwc_consts.vh
// Constants for the reload timer with comparator capture
// Functional notes
// - 16-bit counter in two bytes, split select
// - Clocks: system, system/12, external/8
// - External/8 synchronized except while suspended
// - Counts in suspend, overflow wakes device
// - Sync busy up to three ticks after non-timer wake
// - 16-bit wrap reloads, sets high flag, except in capture
// - Interrupt on full and optional low overflows
// - Split: two 8-bit counters, own reloads
// - Split: run gates high byte only
// - Per-byte select: system or selected clock
// - Split: each byte wrap sets its flag
// - Split interrupts: high, optionally low byte
// - Flags cleared only by software writes
// - Capture only when enabled and not split
// - Comparator rise copies counter, sets flag
// - Low flag on low wrap, every mode
// - External select: system/12 or external/8, system/12 in capture
`ifndef RTWC_CONSTS_VH
`define RTWC_CONSTS_VH
`define RTWC_ADDR_CTRL     8'h00
`define RTWC_ADDR_CNT_LO   8'h04
`define RTWC_ADDR_CNT_HI   8'h08
`define RTWC_ADDR_RL_LO    8'h0C
`define RTWC_ADDR_RL_HI    8'h10
`define RTWC_ADDR_CLKCTL   8'h14
`define RTWC_ADDR_STATUS   8'h18
`define RTWC_BIT_HFLAG     7
`define RTWC_BIT_LFLAG     6
`define RTWC_BIT_LIRQEN    5
`define RTWC_BIT_CAPEN     4
`define RTWC_BIT_SPLIT     3
`define RTWC_BIT_RUN       2
`define RTWC_BIT_XCLK      0
`define RTWC_BIT_LOSEL     0
`define RTWC_BIT_HISEL     1
`define RTWC_BIT_IRQEN     2
`define RTWC_BIT_BUSY      0
`define RTWC_BIT_SUSP      1
`define RTWC_DIV_SYS_LAST  4'hB
`define RTWC_DIV_EXT_LAST  3'h7
`define RTWC_SYNC_TICKS    2'h3
`define RTWC_BYTE_MAX      8'hFF
`define RTWC_RESP_OKAY     2'h0
`define RTWC_RESP_SLVERR   2'h2
`endif

//--- src/rtwc_prescaler.v
// Tick generator for system/12 and external/8 timer clocks
`timescale 1ns/1ps
`default_nettype none
`include "rtwc_consts.vh"
module rtwc_prescaler (
  input  wire aclk,
  input  wire aresetn,
  input  wire ce,
  input  wire suspend,
  input  wire ext_osc_clk,
  output reg  tick_sys12,
  output reg  tick_ext8
);
  reg [3:0] div_sys;
  reg [2:0] div_ext;
  reg       ext_meta;
  reg       ext_sync;
  reg       ext_sync_q;
  reg       ext_raw_q;
  reg       ext_direct_q;
  wire      edge_sync;
  wire      edge_direct;
  wire      ext_edge;
  // Synchronized edge normally, direct in suspend
  assign edge_sync   = ext_sync & ~ext_sync_q;
  assign edge_direct = ext_raw_q & ~ext_direct_q;
  assign ext_edge    = suspend ? edge_direct : edge_sync;
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_sys      <= 4'h0;
      div_ext      <= 3'h0;
      ext_meta     <= 1'h0;
      ext_sync     <= 1'h0;
      ext_sync_q   <= 1'h0;
      ext_raw_q    <= 1'h0;
      ext_direct_q <= 1'h0;
      tick_sys12   <= 1'h0;
      tick_ext8    <= 1'h0;
    end else if (ce) begin
      ext_meta     <= ext_osc_clk;
      ext_sync     <= ext_meta;
      ext_sync_q   <= ext_sync;
      ext_raw_q    <= ext_osc_clk;
      ext_direct_q <= ext_raw_q;
      if (div_sys == `RTWC_DIV_SYS_LAST) begin
        div_sys    <= 4'h0;
        tick_sys12 <= 1'h1;
      end else begin
        div_sys    <= div_sys + 4'h1;
        tick_sys12 <= 1'h0;
      end
      tick_ext8 <= 1'h0;
      if (ext_edge) begin
        div_ext <= div_ext + 3'h1;
        if (div_ext == `RTWC_DIV_EXT_LAST) begin
          tick_ext8 <= 1'h1;
        end
      end
    end
  end
endmodule // rtwc_prescaler
`default_nettype wire

//--- src/rtwc_top.v
// Reload timer with split mode and comparator capture, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "rtwc_consts.vh"
module rtwc_top #(
  parameter AW = 8
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          ce,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          suspend,
  input  wire          ext_osc_clk,
  input  wire          comparator_out,
  output reg           timer_irq,
  output reg           wake
);
  reg        high_overflow_flag;
  reg        low_overflow_flag;
  reg        low_overflow_irq_enable;
  reg        comparator_capture_enable;
  reg        split_mode_select;
  reg        run_control;
  reg        external_clock_select;
  reg        low_byte_clock_select;
  reg        high_byte_clock_select;
  reg        timer_irq_enable;
  reg [7:0]  count_low_byte;
  reg [7:0]  count_high_byte;
  reg [7:0]  reload_low_byte;
  reg [7:0]  reload_high_byte;
  reg        sync_busy_flag;
  reg [1:0]  busy_ticks;
  reg        suspend_q;
  reg        wake_sent;
  reg        comp_q;
  reg [7:0]  next_lo;
  reg [7:0]  next_hi;
  reg [7:0]  next_rl_lo;
  reg [7:0]  next_rl_hi;
  reg        set_high;
  reg        set_low;
  reg [31:0] read_word;
  reg        read_hit;
  wire       tick_sys12;
  wire       tick_ext8;
  wire       wr_fire;
  wire       rd_fire;
  wire [7:0] wr_addr;
  wire [7:0] rd_addr;
  wire [7:0] wbyte;
  wire       wr_lane;
  wire       wr_ctrl;
  wire       wr_clk;
  wire       wr_cnt_lo;
  wire       wr_cnt_hi;
  wire       wr_rl_lo;
  wire       wr_rl_hi;
  wire       wr_hit;
  wire       capture_mode;
  wire       xclk_eff;
  wire       lo_tick;
  wire       hi_tick;
  wire       comp_rise;
  wire       wake_event;
  wire       other_wake;

  rtwc_prescaler u_prescaler (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .suspend     (suspend),
    .ext_osc_clk (ext_osc_clk),
    .tick_sys12  (tick_sys12),
    .tick_ext8   (tick_ext8)
  );

  // Write and read handshakes
  assign wr_fire       = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign rd_fire       = ce & s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_fire;
  assign wr_addr       = s_axi_awaddr[7:0];
  assign rd_addr       = s_axi_araddr[7:0];
  assign wbyte         = s_axi_wdata[7:0];
  assign wr_lane       = wr_fire & s_axi_wstrb[0];
  assign wr_ctrl       = wr_lane & (wr_addr == `RTWC_ADDR_CTRL);
  assign wr_clk        = wr_lane & (wr_addr == `RTWC_ADDR_CLKCTL);
  // Counter and reload writes blocked while busy
  assign wr_cnt_lo = wr_lane & ~sync_busy_flag & (wr_addr == `RTWC_ADDR_CNT_LO);
  assign wr_cnt_hi = wr_lane & ~sync_busy_flag & (wr_addr == `RTWC_ADDR_CNT_HI);
  assign wr_rl_lo  = wr_lane & ~sync_busy_flag & (wr_addr == `RTWC_ADDR_RL_LO);
  assign wr_rl_hi  = wr_lane & ~sync_busy_flag & (wr_addr == `RTWC_ADDR_RL_HI);
  assign wr_hit    = (wr_addr == `RTWC_ADDR_CTRL) | (wr_addr == `RTWC_ADDR_CNT_LO) |
                     (wr_addr == `RTWC_ADDR_CNT_HI) | (wr_addr == `RTWC_ADDR_RL_LO) |
                     (wr_addr == `RTWC_ADDR_RL_HI) | (wr_addr == `RTWC_ADDR_CLKCTL) |
                     (wr_addr == `RTWC_ADDR_STATUS);

  // Capture only with enable set and split clear
  assign capture_mode = comparator_capture_enable & ~split_mode_select;
  // External select, no external clock in capture
  assign xclk_eff = external_clock_select & ~capture_mode;
  // Per-byte system clock or selected clock
  assign lo_tick = low_byte_clock_select ? 1'h1 : (xclk_eff ? tick_ext8 : tick_sys12);
  assign hi_tick = high_byte_clock_select ? 1'h1 : (xclk_eff ? tick_ext8 : tick_sys12);
  assign comp_rise = comparator_out & ~comp_q;

  // Counter, reload and flag events
  always @* begin
    next_lo    = count_low_byte;
    next_hi    = count_high_byte;
    next_rl_lo = wr_rl_lo ? wbyte : reload_low_byte;
    next_rl_hi = wr_rl_hi ? wbyte : reload_high_byte;
    set_high   = 1'h0;
    set_low    = 1'h0;
    if (capture_mode) begin
      // Comparator rise copies counter to reload
      if (comp_rise) begin
        next_rl_lo = count_low_byte;
        next_rl_hi = count_high_byte;
        set_high   = 1'h1;
      end
      if (run_control & lo_tick) begin
        {next_hi, next_lo} = {count_high_byte, count_low_byte} + 16'h0001;
        // Low wrap flag in capture mode
        set_low = (count_low_byte == `RTWC_BYTE_MAX);
      end
    end else if (!split_mode_select) begin
      // 16-bit wrap reloads and sets high flag
      if (run_control & lo_tick) begin
        if ({count_high_byte, count_low_byte} == {`RTWC_BYTE_MAX, `RTWC_BYTE_MAX}) begin
          next_lo  = reload_low_byte;
          next_hi  = reload_high_byte;
          set_high = 1'h1;
        end else begin
          {next_hi, next_lo} = {count_high_byte, count_low_byte} + 16'h0001;
        end
        // Low wrap flag in 16-bit mode
        set_low = (count_low_byte == `RTWC_BYTE_MAX);
      end
    end else begin
      // Low byte always runs in split mode
      if (lo_tick) begin
        if (count_low_byte == `RTWC_BYTE_MAX) begin
          next_lo = reload_low_byte;
          // Low byte wrap sets low flag
          set_low = 1'h1;
        end else begin
          next_lo = count_low_byte + 8'h01;
        end
      end
      // Run control gates high byte only
      if (run_control & hi_tick) begin
        if (count_high_byte == `RTWC_BYTE_MAX) begin
          next_hi  = reload_high_byte;
          // High byte wrap sets high flag
          set_high = 1'h1;
        end else begin
          next_hi = count_high_byte + 8'h01;
        end
      end
    end
    if (wr_cnt_lo) begin
      next_lo = wbyte;
    end
    if (wr_cnt_hi) begin
      next_hi = wbyte;
    end
  end

  assign wake_event = suspend & (set_high | (low_overflow_irq_enable & set_low));
  assign other_wake = suspend_q & ~suspend & ~wake_sent;

  // Register read mux
  always @* begin
    read_word = 32'h00000000;
    read_hit  = 1'h1;
    case (rd_addr)
      `RTWC_ADDR_CTRL: begin
        read_word[`RTWC_BIT_HFLAG]  = high_overflow_flag;
        read_word[`RTWC_BIT_LFLAG]  = low_overflow_flag;
        read_word[`RTWC_BIT_LIRQEN] = low_overflow_irq_enable;
        read_word[`RTWC_BIT_CAPEN]  = comparator_capture_enable;
        read_word[`RTWC_BIT_SPLIT]  = split_mode_select;
        read_word[`RTWC_BIT_RUN]    = run_control;
        read_word[`RTWC_BIT_XCLK]   = external_clock_select;
      end
      `RTWC_ADDR_CNT_LO: read_word[7:0] = count_low_byte;
      `RTWC_ADDR_CNT_HI: read_word[7:0] = count_high_byte;
      `RTWC_ADDR_RL_LO:  read_word[7:0] = reload_low_byte;
      `RTWC_ADDR_RL_HI:  read_word[7:0] = reload_high_byte;
      `RTWC_ADDR_CLKCTL: begin
        read_word[`RTWC_BIT_LOSEL] = low_byte_clock_select;
        read_word[`RTWC_BIT_HISEL] = high_byte_clock_select;
        read_word[`RTWC_BIT_IRQEN] = timer_irq_enable;
      end
      `RTWC_ADDR_STATUS: begin
        read_word[`RTWC_BIT_BUSY] = sync_busy_flag;
        read_word[`RTWC_BIT_SUSP] = suspend_q;
      end
      default: read_hit = 1'h0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      high_overflow_flag        <= 1'h0;
      low_overflow_flag         <= 1'h0;
      low_overflow_irq_enable   <= 1'h0;
      comparator_capture_enable <= 1'h0;
      split_mode_select         <= 1'h0;
      run_control               <= 1'h0;
      external_clock_select     <= 1'h0;
      low_byte_clock_select     <= 1'h0;
      high_byte_clock_select    <= 1'h0;
      timer_irq_enable          <= 1'h0;
      count_low_byte            <= 8'h00;
      count_high_byte           <= 8'h00;
      reload_low_byte           <= 8'h00;
      reload_high_byte          <= 8'h00;
      sync_busy_flag            <= 1'h0;
      busy_ticks                <= 2'h0;
      suspend_q                 <= 1'h0;
      wake_sent                 <= 1'h0;
      comp_q                    <= 1'h0;
      timer_irq                 <= 1'h0;
      wake                      <= 1'h0;
      s_axi_bvalid              <= 1'h0;
      s_axi_bresp               <= `RTWC_RESP_OKAY;
      s_axi_rvalid              <= 1'h0;
      s_axi_rresp               <= `RTWC_RESP_OKAY;
      s_axi_rdata               <= 32'h00000000;
    end else if (ce) begin
      comp_q          <= comparator_out;
      suspend_q       <= suspend;
      // Two byte registers form the counter
      count_low_byte   <= next_lo;
      count_high_byte  <= next_hi;
      reload_low_byte  <= next_rl_lo;
      reload_high_byte <= next_rl_hi;
      // Flags set by hardware, cleared by software
      high_overflow_flag <= (wr_ctrl ? wbyte[`RTWC_BIT_HFLAG] : high_overflow_flag) | set_high;
      low_overflow_flag  <= (wr_ctrl ? wbyte[`RTWC_BIT_LFLAG] : low_overflow_flag) | set_low;
      if (wr_ctrl) begin
        low_overflow_irq_enable   <= wbyte[`RTWC_BIT_LIRQEN];
        comparator_capture_enable <= wbyte[`RTWC_BIT_CAPEN];
        split_mode_select         <= wbyte[`RTWC_BIT_SPLIT];
        run_control               <= wbyte[`RTWC_BIT_RUN];
        external_clock_select     <= wbyte[`RTWC_BIT_XCLK];
      end
      if (wr_clk) begin
        low_byte_clock_select  <= wbyte[`RTWC_BIT_LOSEL];
        high_byte_clock_select <= wbyte[`RTWC_BIT_HISEL];
        timer_irq_enable       <= wbyte[`RTWC_BIT_IRQEN];
      end
      // Interrupt on high flag, low flag if enabled
      // Same shared interrupt in split mode
      timer_irq <= timer_irq_enable &
                   (high_overflow_flag | (low_overflow_irq_enable & low_overflow_flag));
      // Wake pulse on overflow in suspend
      wake <= wake_event;
      if (wake_event) begin
        wake_sent <= 1'h1;
      end else if (!suspend) begin
        wake_sent <= 1'h0;
      end
      // Busy for three external ticks after other wake
      if (other_wake) begin
        sync_busy_flag <= 1'h1;
        busy_ticks     <= 2'h0;
      end else if (sync_busy_flag & tick_ext8) begin
        if (busy_ticks == `RTWC_SYNC_TICKS - 2'h1) begin
          sync_busy_flag <= 1'h0;
        end
        busy_ticks <= busy_ticks + 2'h1;
      end
      // Write response
      if (wr_fire) begin
        s_axi_bvalid <= 1'h1;
        s_axi_bresp  <= wr_hit ? `RTWC_RESP_OKAY : `RTWC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
      // Read response
      if (rd_fire) begin
        s_axi_rvalid <= 1'h1;
        s_axi_rdata  <= read_word;
        s_axi_rresp  <= read_hit ? `RTWC_RESP_OKAY : `RTWC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
    end
  end
endmodule // rtwc_top
`default_nettype wire

//--- testbench/rtwc_far_side.sv
// Far-side model: external oscillator and comparator output
`timescale 1ns/1ps
`default_nettype none
module rtwc_far_side #(
  parameter int EXT_HALF = 21
) (
  input  wire logic aclk,
  input  wire logic cmp_fire,
  output var  logic ext_osc_clk,
  output var  logic comparator_out
);
  initial begin
    ext_osc_clk = 1'b0;
    #3;
    forever #(EXT_HALF) ext_osc_clk = ~ext_osc_clk;
  end
  always @(posedge aclk) comparator_out <= cmp_fire;
endmodule // rtwc_far_side
`default_nettype wire

//--- testbench/rtwc_sva.sv
// Bus and wake checks on the timer top ports
`timescale 1ns/1ps
`default_nettype none
module rtwc_sva (
  input wire logic        aclk, aresetn, ce, wake,
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
  a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_ce_freeze: assert property (!ce |-> !(s_axi_awready || s_axi_wready || s_axi_arready))
    else $error("ready while clock enable low");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
endmodule // rtwc_sva
bind rtwc_top rtwc_sva u_sva (.aclk, .aresetn, .ce, .wake, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_rdata);
`default_nettype wire

//--- testbench/rtwc_top_tb.sv
// Self-checking bench for the reload timer
`timescale 1ns/1ps
`default_nettype none
`include "rtwc_consts.vh"
module rtwc_top_tb;
  localparam [7:0] CT = `RTWC_ADDR_CTRL, CL = `RTWC_ADDR_CNT_LO, CH = `RTWC_ADDR_CNT_HI;
  localparam [7:0] RL = `RTWC_ADDR_RL_LO, RH = `RTWC_ADDR_RL_HI, CK = `RTWC_ADDR_CLKCTL;
  localparam [7:0] ST = `RTWC_ADDR_STATUS;
  localparam int EXT_HALF = 21;
  logic aclk, aresetn, ce, suspend, cmp_fire, ext_osc_clk, comparator_out, timer_irq, wake;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, slow_b, seen;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data, seed;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [3:0] s_axi_wstrb;
  int mismatches = 0, num_checks = 0, cyc = 0, n;
  rtwc_top u_dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .suspend, .ext_osc_clk, .comparator_out, .timer_irq, .wake
  );
  rtwc_far_side #(.EXT_HALF(EXT_HALF)) u_far (.aclk, .cmp_fire, .ext_osc_clk, .comparator_out);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int ticks(input int cycles, input int per_ns);
    return cycles * 8 / per_ns;
  endfunction
  function automatic logic ok(input logic [31:0] got, input int e);
    return got >= e - 1 && got <= e + 2;
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow_b;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    if (slow_b) begin
      repeat (3) @(posedge aclk);
      s_axi_bready <= 1'b1;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, (a > ST) ? 2'h2 : 2'h0, "bresp");
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string what);
    rd(a);
    chk(rd_data, {24'h000000, e}, what);
  endtask
  task automatic pulse_cmp;
    cmp_fire <= 1'b1;
    repeat (4) @(posedge aclk);
    cmp_fire <= 1'b0;
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict;
    end
  end
  initial begin
    {aresetn, suspend, cmp_fire, slow_b, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ce, s_axi_wstrb} = {1'b1, 4'hF};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rchk(8'(4 * i), 8'h00, "reset value");
    rd(8'h1C);
    chk(rd_resp, 2'h2, "unmapped rresp");
    wr(8'h1C, 8'h5A);
    seed = 32'h5BF6;
    repeat (4) begin
      seed = lfsr(seed);
      wr(RL, seed[7:0]);
      wr(RH, seed[15:8]);
      rchk(RL, seed[7:0], "reload low");
      rchk(RH, seed[15:8], "reload high");
    end
    slow_b = 1'b1;
    wr(CK, 8'h01);
    slow_b = 1'b0;
    ce <= 1'b0;
    repeat (4) @(posedge aclk);
    ce <= 1'b1;
    wr(RL, 8'h34); wr(RH, 8'h12); wr(CH, 8'hFF); wr(CL, 8'hF0); wr(CT, 8'h04);
    repeat (30) @(posedge aclk);
    rchk(CT, 8'hC4, "wrap flags");
    rchk(CH, 8'h12, "reloaded high");
    wr(CK, 8'h05);
    repeat (2) @(posedge aclk);
    chk(timer_irq, 1'b1, "irq on wrap");
    rchk(CT, 8'hC4, "flags kept");
    wr(CT, 8'h00);
    repeat (2) @(posedge aclk);
    chk(timer_irq, 1'b0, "irq after clear");
    wr(CT, 8'h24);
    repeat (300) @(posedge aclk);
    chk(timer_irq, 1'b1, "low wrap irq");
    rchk(CT, 8'h64, "low flag 16-bit");
    wr(CT, 8'h00); wr(CL, 8'hF8); wr(CH, 8'h55); wr(RL, 8'hA0); wr(CT, 8'h08);
    repeat (20) @(posedge aclk);
    rchk(CH, 8'h55, "split high idle");
    rchk(CT, 8'h48, "split low flag");
    chk(timer_irq, 1'b0, "irq without low enable");
    rd(CL);
    chk(rd_data >= 32'h000000A0, 1'b1, "low reload");
    wr(CH, 8'hFC); wr(CT, 8'h2C);
    repeat (60) @(posedge aclk);
    rd(CT);
    chk(rd_data[7], 1'b1, "split high flag");
    chk(timer_irq, 1'b1, "split irq");
    rd(CH);
    chk(rd_data >= 32'h00000012 && rd_data < 32'h00000030, 1'b1, "high reload");
    wr(CT, 8'h00); wr(CK, 8'h00); wr(CL, 8'h00); wr(CH, 8'h00); wr(CT, 8'h04);
    repeat (240) @(posedge aclk);
    wr(CT, 8'h00);
    rd(CL);
    chk(ok(rd_data, ticks(242, 96)), 1'b1, "system/12 rate");
    wr(CT, 8'h01); wr(CL, 8'h00); wr(CT, 8'h05);
    repeat (640) @(posedge aclk);
    wr(CT, 8'h01);
    rd(CL);
    chk(ok(rd_data, ticks(642, 16 * EXT_HALF)), 1'b1, "external/8 rate");
    wr(CH, 8'hFF); wr(CL, 8'hFD); wr(CT, 8'h05);
    suspend <= 1'b1;
    n = 0;
    seen = 1'b0;
    while (!seen && n < 400) begin
      @(posedge aclk);
      seen = wake;
      n++;
    end
    chk(seen, 1'b1, "wake on overflow");
    chk(n > 40 && n < 200, 1'b1, "wake delay");
    suspend <= 1'b0;
    repeat (6) @(posedge aclk);
    rchk(ST, 8'h00, "no busy after timer wake");
    wr(CT, 8'h01);
    suspend <= 1'b1;
    repeat (20) @(posedge aclk);
    suspend <= 1'b0;
    repeat (3) @(posedge aclk);
    rchk(ST, 8'h01, "busy after other wake");
    n = 0;
    do begin
      rd(ST);
      n++;
    end while (rd_data[0] && n < 100);
    chk(n < 90, 1'b1, "busy ends");
    wr(CK, 8'h01); wr(CH, 8'h40); wr(CL, 8'h00); wr(RL, 8'h00); wr(CT, 8'h14);
    ce <= 1'b0;
    repeat (40) @(posedge aclk);
    ce <= 1'b1;
    repeat (20) @(posedge aclk);
    pulse_cmp;
    rd(CT);
    chk(rd_data[7], 1'b1, "capture flag");
    rchk(RH, 8'h40, "captured high");
    rd(RL);
    chk(rd_data > 32'h00000010 && rd_data < 32'h00000030, 1'b1, "captured low");
    wr(RH, 8'h99); wr(CT, 8'h18);
    pulse_cmp;
    rchk(RH, 8'h99, "no capture in split");
    rd(CT);
    chk(rd_data[7], 1'b0, "no capture flag");
    give_verdict;
  end
endmodule // rtwc_top_tb
`default_nettype wire
